// ==== shared/fsrb_pkg.sv ====
// Constants, encodings and carrier types for the serial flash command front end.
// Assumes one 100 MHz system clock; pins are sampled through a three-stage synchroniser.
package fsrb_pkg;

  // Command opcodes
  localparam logic [7:0] OPC_RD_HI  = 8'h0b;
  localparam logic [7:0] OPC_RD_LO  = 8'h03;
  localparam logic [7:0] OPC_PG_RD  = 8'hd2;
  localparam logic [7:0] OPC_BR1_HI = 8'hd4;
  localparam logic [7:0] OPC_BR1_LO = 8'hd1;
  localparam logic [7:0] OPC_BR2_HI = 8'hd6;
  localparam logic [7:0] OPC_BR2_LO = 8'hd3;
  localparam logic [7:0] OPC_BW1    = 8'h84;
  localparam logic [7:0] OPC_BW2    = 8'h87;
  localparam logic [7:0] OPC_PE1    = 8'h83;
  localparam logic [7:0] OPC_PE2    = 8'h86;

  // Address layout
  localparam int         PAGE_W     = 12;
  localparam int         COL_W      = 9;
  localparam int         A264_PG_LSB = 9;
  localparam int         A256_PG_LSB = 8;
  localparam logic [8:0] LAST_264   = 9'h107;
  localparam logic [8:0] LAST_256   = 9'h0ff;
  localparam int         NUM_BUF    = 2;
  localparam int         BUF_BYTES  = 264;

  // Last bit index of the opcode and address phases; bit counts of the dummy phase
  localparam logic [5:0] OPC_LAST   = 6'h07;
  localparam logic [5:0] ADDR_LAST  = 6'h17;
  localparam logic [5:0] DMY_NONE   = 6'h00;
  localparam logic [5:0] DMY_ONE    = 6'h08;
  localparam logic [5:0] DMY_FOUR   = 6'h20;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Synchroniser lanes {page_264, si, sck, cs_n}; cs_n idles high
  localparam int         SYNC_W     = 4;
  localparam logic [3:0] SYNC_RST   = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_RD    = 3'b100,
    ST_WR    = 3'b101,
    ST_PARM  = 3'b110,
    ST_SKIP  = 3'b111
  } fsrb_state_t;

  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_CONT  = 3'b001,
    K_PAGE  = 3'b010,
    K_BUFRD = 3'b011,
    K_BUFWR = 3'b100,
    K_PROG  = 3'b101
  } fsrb_kind_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_ERASE = 2'b01,
    PG_WRITE = 2'b10
  } fsrb_pg_t;

  // Request to the main array
  typedef struct packed {
    logic             re;
    logic             we;
    logic [11:0]      page;
    logic [8:0]       col;
    logic [7:0]       wdata;
  } fsrb_arr_req_t;

endpackage : fsrb_pkg

// ==== design/fsrb_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fsrb_pin_sync
#(
  parameter int             W       = 4,
  parameter logic [W-1:0]   RST_VAL = '0
)
(
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic [W-1:0]  pin_in,
  output logic      [W-1:0]  level
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lv_q;
      logic lv_d;

      // Accept a change only once stages two and three agree
      always_comb
      begin
        lv_d = (s2_q == s3_q) ? s2_q : lv_q;
      end

      // First stage feeds only the second stage
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_q <= RST_VAL[g];
          s2_q <= RST_VAL[g];
          s3_q <= RST_VAL[g];
          lv_q <= RST_VAL[g];
        end
        else
        begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lv_q <= lv_d;
        end
      end

      assign level[g] = lv_q;
    end
  endgenerate

endmodule : fsrb_pin_sync
`default_nettype wire

// ==== design/fsrb_core.sv ====
// Serial flash command front end: array reads, buffer read/write, buffer-to-page program.
// Assumes a synchronous main array: arr_rdata is valid the cycle after arr_req.re was high.
// Function
// - 0BH read: opcode, address, one dummy byte
// - 264 mode: 12 page bits, 9 byte bits
// - 256 mode: 12 page bits, 8 byte bits
// - Continuous read rolls into next page seamlessly
// - End of array wraps to page zero
// - Chip select high ends read, releases output
// - Array reads never touch either buffer
// - 03H read: data right after address
// - D2H page read: four dummy bytes
// - Page read wraps within same page
// - D4H/D1H buffer one, D6H/D3H buffer two
// - Buffer address keeps only buffer index bits
// - Buffer read takes one dummy byte
// - Buffer read wraps to buffer start
// - 84H/87H buffer write, data follows address
// - Buffer write wraps, stores until deselect
// - 83H/86H program buffer with erase
// - 264 mode program: 3 skip, 12 page, 9 skip
// - 256 mode program: 4 skip, 12 page, 8 skip
// - Deselect erases page then writes buffer
// - Busy reported during erase and program
// - All link bytes travel MSB first
// - Falling select starts frame, eight opcode bits
`timescale 1ns/1ps
`default_nettype none
module fsrb_core
(
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    cs_n_pin,
  input  wire logic                    sck_pin,
  input  wire logic                    si_pin,
  input  wire logic                    page_264_pin,
  output logic                         so_o,
  output logic                         so_oe,
  output logic                         busy,
  output fsrb_pkg::fsrb_arr_req_t      arr_req,
  input  wire logic [7:0]              arr_rdata
);

  logic [3:0]                 lv;
  logic                       cs_s;
  logic                       sck_s;
  logic                       si_s;
  logic                       p264;
  logic                       sck_prev_q;
  logic                       sck_rise;
  logic                       sck_fall;
  fsrb_pkg::fsrb_state_t      st_q, st_d;
  fsrb_pkg::fsrb_kind_t       kind_q, kind_d;
  logic                       bsel_q, bsel_d;
  logic [5:0]                 cnt_q, cnt_d;
  logic [5:0]                 dmy_q, dmy_d;
  logic [22:0]                sh_in_q, sh_in_d;
  logic [11:0]                page_q, page_d;
  logic [8:0]                 col_q, col_d;
  logic [2:0]                 obit_q, obit_d;
  logic [7:0]                 sh_out_q, sh_out_d;
  logic                       so_q, so_d;
  logic                       oe_q, oe_d;
  logic [7:0]                 nxt_q, nxt_d;
  logic                       fetch_q, fetch_d;
  logic                       cap_q;
  logic                       start_prog;
  logic                       bw_en;
  logic [7:0]                 in_byte;
  logic [23:0]                in_addr;
  logic [8:0]                 last_col;
  logic [11:0]                pg_new;
  logic [8:0]                 col_new;
  logic [7:0]                 buf_rd;
  logic [7:0]                 pg_buf_rd;
  fsrb_pkg::fsrb_pg_t         pg_st_q, pg_st_d;
  logic [11:0]                pg_page_q, pg_page_d;
  logic [8:0]                 pg_col_q, pg_col_d;
  logic                       pg_buf_q, pg_buf_d;
  logic                       busy_q, busy_d;
  fsrb_pkg::fsrb_arr_req_t    arr_q, arr_d;
  logic [7:0]                 buf_mem [fsrb_pkg::NUM_BUF][fsrb_pkg::BUF_BYTES];

  fsrb_pin_sync #(
    .W       (fsrb_pkg::SYNC_W),
    .RST_VAL (fsrb_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin_in  ({page_264_pin, si_pin, sck_pin, cs_n_pin}),
    .level   (lv)
  );

  // Filtered pin levels and link clock edges
  assign cs_s     = lv[0];
  assign sck_s    = lv[1];
  assign si_s     = lv[2];
  assign p264     = lv[3];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // Incoming bits shift in MSB first
  assign in_byte  = {sh_in_q[6:0], si_s};
  assign in_addr  = {sh_in_q, si_s};
  // Page size is a static strap, read live for parsing, read and write wrap columns and the program engine
  assign last_col = p264 ? fsrb_pkg::LAST_264 : fsrb_pkg::LAST_256;

  // Address split; buffer commands reuse the low field and ignore the rest
  assign pg_new  = p264 ? in_addr[fsrb_pkg::A264_PG_LSB +: fsrb_pkg::PAGE_W]
                        : in_addr[fsrb_pkg::A256_PG_LSB +: fsrb_pkg::PAGE_W];
  assign col_new = p264 ? in_addr[fsrb_pkg::COL_W-1:0]
                        : {1'b0, in_addr[fsrb_pkg::COL_W-2:0]};

  assign buf_rd    = buf_mem[bsel_q][col_q];
  assign pg_buf_rd = buf_mem[pg_buf_q][pg_col_q];

  // Frame sequencer: opcode, address, dummy, then data phase
  always_comb
  begin
    st_d       = st_q;
    kind_d     = kind_q;
    bsel_d     = bsel_q;
    cnt_d      = cnt_q;
    dmy_d      = dmy_q;
    sh_in_d    = sh_in_q;
    page_d     = page_q;
    col_d      = col_q;
    obit_d     = obit_q;
    sh_out_d   = sh_out_q;
    so_d       = so_q;
    nxt_d      = cap_q ? ((kind_q == fsrb_pkg::K_BUFRD) ? buf_rd : arr_rdata) : nxt_q;
    fetch_d    = 1'b0;
    bw_en      = 1'b0;
    start_prog = 1'b0;
    if (cs_s)
    begin
      // Deselect ends any read; an armed program starts here
      st_d       = fsrb_pkg::ST_IDLE;
      start_prog = (st_q == fsrb_pkg::ST_PARM);
    end
    else
    begin
      unique case (st_q)
        fsrb_pkg::ST_IDLE:
        begin
          st_d  = fsrb_pkg::ST_OPC;
          cnt_d = '0;
        end
        fsrb_pkg::ST_OPC:
          if (sck_rise)
          begin
            sh_in_d = in_addr[22:0];
            cnt_d   = cnt_q + 6'h01;
            if (cnt_q == fsrb_pkg::OPC_LAST)
            begin
              bsel_d = 1'b0;
              dmy_d  = fsrb_pkg::DMY_NONE;
              unique case (in_byte)
                fsrb_pkg::OPC_RD_HI:  begin kind_d = fsrb_pkg::K_CONT;  dmy_d = fsrb_pkg::DMY_ONE; end
                fsrb_pkg::OPC_RD_LO:  kind_d = fsrb_pkg::K_CONT;
                fsrb_pkg::OPC_PG_RD:  begin kind_d = fsrb_pkg::K_PAGE;  dmy_d = fsrb_pkg::DMY_FOUR; end
                fsrb_pkg::OPC_BR1_HI,
                fsrb_pkg::OPC_BR1_LO: begin kind_d = fsrb_pkg::K_BUFRD; dmy_d = fsrb_pkg::DMY_ONE; end
                fsrb_pkg::OPC_BR2_HI,
                fsrb_pkg::OPC_BR2_LO: begin kind_d = fsrb_pkg::K_BUFRD; dmy_d = fsrb_pkg::DMY_ONE;
                                            bsel_d = 1'b1; end
                fsrb_pkg::OPC_BW1:    kind_d = fsrb_pkg::K_BUFWR;
                fsrb_pkg::OPC_BW2:    begin kind_d = fsrb_pkg::K_BUFWR; bsel_d = 1'b1; end
                fsrb_pkg::OPC_PE1:    kind_d = fsrb_pkg::K_PROG;
                fsrb_pkg::OPC_PE2:    begin kind_d = fsrb_pkg::K_PROG; bsel_d = 1'b1; end
                default:              kind_d = fsrb_pkg::K_NONE;
              endcase
              cnt_d = '0;
              // Array access is refused while the array is busy
              if (kind_d == fsrb_pkg::K_NONE || (busy_q && kind_d != fsrb_pkg::K_BUFRD
                  && kind_d != fsrb_pkg::K_BUFWR))
                st_d = fsrb_pkg::ST_SKIP;
              else
                st_d = fsrb_pkg::ST_ADDR;
            end
          end
        fsrb_pkg::ST_ADDR:
          if (sck_rise)
          begin
            sh_in_d = in_addr[22:0];
            cnt_d   = cnt_q + 6'h01;
            if (cnt_q == fsrb_pkg::ADDR_LAST)
            begin
              page_d = pg_new;
              col_d  = col_new;
              cnt_d  = '0;
              obit_d = '0;
              if (kind_q == fsrb_pkg::K_PROG)
                st_d = fsrb_pkg::ST_PARM;
              else if (kind_q == fsrb_pkg::K_BUFWR)
                st_d = fsrb_pkg::ST_WR;
              else if (dmy_q == fsrb_pkg::DMY_NONE)
              begin
                st_d    = fsrb_pkg::ST_RD;
                fetch_d = 1'b1;
              end
              else
                st_d = fsrb_pkg::ST_DUMMY;
            end
          end
        fsrb_pkg::ST_DUMMY:
          if (sck_rise)
          begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_d == dmy_q)
            begin
              st_d    = fsrb_pkg::ST_RD;
              fetch_d = 1'b1;
            end
          end
        fsrb_pkg::ST_RD:
          if (sck_fall)
          begin
            obit_d = obit_q + 3'h1;
            if (obit_q == 3'h0)
            begin
              // Byte boundary: present prefetched byte, advance and prefetch
              so_d     = nxt_q[7];
              sh_out_d = {nxt_q[6:0], 1'b0};
              fetch_d  = 1'b1;
              if (col_q == last_col)
              begin
                col_d = '0;
                if (kind_q == fsrb_pkg::K_CONT)
                  page_d = page_q + 12'h001;
              end
              else
                col_d = col_q + 9'h001;
            end
            else
            begin
              so_d     = sh_out_q[7];
              sh_out_d = {sh_out_q[6:0], 1'b0};
            end
          end
        fsrb_pkg::ST_WR:
          if (sck_rise)
          begin
            sh_in_d = in_addr[22:0];
            cnt_d   = cnt_q + 6'h01;
            if (cnt_q[2:0] == 3'h7)
            begin
              bw_en = 1'b1;
              col_d = (col_q == last_col) ? '0 : col_q + 9'h001;
            end
          end
        fsrb_pkg::ST_PARM,
        fsrb_pkg::ST_SKIP:
          st_d = st_q;
      endcase
    end
    oe_d = (st_d == fsrb_pkg::ST_RD);
  end

  // Frame state registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_prev_q <= 1'b0;
      st_q       <= fsrb_pkg::ST_IDLE;
      kind_q     <= fsrb_pkg::K_NONE;
      bsel_q     <= 1'b0;
      cnt_q      <= '0;
      dmy_q      <= '0;
      sh_in_q    <= '0;
      page_q     <= '0;
      col_q      <= '0;
      obit_q     <= '0;
      sh_out_q   <= '0;
      so_q       <= 1'b0;
      oe_q       <= 1'b0;
      nxt_q      <= '0;
      fetch_q    <= 1'b0;
      cap_q      <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_s;
      st_q       <= st_d;
      kind_q     <= kind_d;
      bsel_q     <= bsel_d;
      cnt_q      <= cnt_d;
      dmy_q      <= dmy_d;
      sh_in_q    <= sh_in_d;
      page_q     <= page_d;
      col_q      <= col_d;
      obit_q     <= obit_d;
      sh_out_q   <= sh_out_d;
      so_q       <= so_d;
      oe_q       <= oe_d;
      nxt_q      <= nxt_d;
      fetch_q    <= fetch_d;
      cap_q      <= fetch_q;
    end
  end

  // Buffers change only through the write command; no reset, contents are undefined at power-up
  always_ff @(posedge clk_sys)
  begin
    if (bw_en)
      buf_mem[bsel_q][col_q] <= in_byte;
  end

  // Self-timed program engine: full page of erased bytes, then the buffer image
  always_comb
  begin
    pg_st_d   = pg_st_q;
    pg_page_d = pg_page_q;
    pg_col_d  = pg_col_q;
    pg_buf_d  = pg_buf_q;
    unique case (pg_st_q)
      fsrb_pkg::PG_IDLE:
        if (start_prog)
        begin
          pg_st_d   = fsrb_pkg::PG_ERASE;
          pg_page_d = page_q;
          pg_buf_d  = bsel_q;
          pg_col_d  = '0;
        end
      fsrb_pkg::PG_ERASE:
      begin
        pg_col_d = (pg_col_q == last_col) ? '0 : pg_col_q + 9'h001;
        if (pg_col_q == last_col)
          pg_st_d = fsrb_pkg::PG_WRITE;
      end
      fsrb_pkg::PG_WRITE:
      begin
        pg_col_d = pg_col_q + 9'h001;
        if (pg_col_q == last_col)
          pg_st_d = fsrb_pkg::PG_IDLE;
      end
      default:
        pg_st_d = fsrb_pkg::PG_IDLE;
    endcase
    busy_d = (pg_st_d != fsrb_pkg::PG_IDLE);
  end

  // Array port: program engine owns it while busy, reads are refused meanwhile
  always_comb
  begin
    arr_d = '0;
    if (pg_st_q != fsrb_pkg::PG_IDLE)
    begin
      arr_d.we    = 1'b1;
      arr_d.page  = pg_page_q;
      arr_d.col   = pg_col_q;
      arr_d.wdata = (pg_st_q == fsrb_pkg::PG_ERASE) ? fsrb_pkg::ERASED_BYTE : pg_buf_rd;
    end
    else if (fetch_d && (kind_q == fsrb_pkg::K_CONT || kind_q == fsrb_pkg::K_PAGE))
    begin
      arr_d.re   = 1'b1;
      arr_d.page = page_d;
      arr_d.col  = col_d;
    end
  end

  // Program engine and array port registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pg_st_q   <= fsrb_pkg::PG_IDLE;
      pg_page_q <= '0;
      pg_col_q  <= '0;
      pg_buf_q  <= 1'b0;
      busy_q    <= 1'b0;
      arr_q     <= '0;
    end
    else
    begin
      pg_st_q   <= pg_st_d;
      pg_page_q <= pg_page_d;
      pg_col_q  <= pg_col_d;
      pg_buf_q  <= pg_buf_d;
      busy_q    <= busy_d;
      arr_q     <= arr_d;
    end
  end

  assign so_o    = so_q;
  assign so_oe   = oe_q;
  assign busy    = busy_q;
  assign arr_req = arr_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_erase_start;
    arr_req.we && arr_req.wdata == fsrb_pkg::ERASED_BYTE && arr_req.col == 9'h000;
  endsequence
  sequence s_byte_edge;
    st_q == fsrb_pkg::ST_RD && sck_fall && obit_q == 3'h0 && !cs_s;
  endsequence

  a_oe_off_deselect: assert property (cs_s |=> !so_oe)
    else $error("output enabled while deselected");
  a_lo_read_no_dummy: assert property (st_q == fsrb_pkg::ST_OPC && sck_rise && !cs_s
      && cnt_q == 6'h07 && in_byte == 8'h03 && !busy_q
      |=> kind_q == fsrb_pkg::K_CONT && dmy_q == 6'h00)
    else $error("03h decode wrong");
  a_addr_split_264: assert property (st_q == fsrb_pkg::ST_ADDR && sck_rise && !cs_s
      && cnt_q == 6'h17 && p264 |=> page_q == $past(sh_in_q[19:8]))
    else $error("264 page split wrong");
  a_cont_page_roll: assert property (s_byte_edge ##0 (kind_q == fsrb_pkg::K_CONT
      && col_q == last_col) |=> col_q == 9'h000 && page_q == 12'($past(page_q) + 1))
    else $error("continuous read did not roll page");
  a_page_read_wrap: assert property (s_byte_edge ##0 (kind_q == fsrb_pkg::K_PAGE
      && col_q == last_col) |=> col_q == 9'h000 && $stable(page_q))
    else $error("page read left its page");
  a_msb_first: assert property (s_byte_edge |=> so_o == $past(nxt_q[7]))
    else $error("byte not sent MSB first");
  a_read_no_buf_write: assert property ((kind_q == fsrb_pkg::K_CONT
      || kind_q == fsrb_pkg::K_PAGE) |-> !bw_en)
    else $error("array read wrote a buffer");
  a_buf_write_wrap: assert property (st_q == fsrb_pkg::ST_WR && sck_rise && !cs_s
      && cnt_q[2:0] == 3'h7 && col_q == last_col |=> col_q == 9'h000)
    else $error("buffer write did not wrap");
  a_prog_erase_first: assert property (start_prog |-> ##2 s_erase_start)
    else $error("program did not begin with erase");
  a_prog_busy: assert property (start_prog |=> busy [*8])
    else $error("busy not shown during program");
  a_fetch_on_entry: assert property ($rose(st_q == fsrb_pkg::ST_RD)
      && kind_q == fsrb_pkg::K_CONT |-> arr_req.re)
    else $error("no prefetch on data phase entry");

endmodule : fsrb_core
`default_nettype wire

// ==== tb/fsrb_host_model.sv ====
// Host controller model: drives select, clock and data in mode 0, samples SO.
// Assumes pacing by clk_sys; one SCK half period is four system clocks.
`timescale 1ns/1ps
`default_nettype none
module fsrb_host_model
(
  input  wire logic clk_sys,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  // Idle bus: deselected, clock low
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Half of an 80 ns SCK period, launched just after a clk_sys edge
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : half

  // Falling select opens the frame
  task automatic start();
    cs_n = 1'b0;
    half();
  endtask : start

  // One byte each way; reply sampled late, since SO moves after the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si = tx[i];
      half();
      sck = 1'b1;
      half();
      rx[i] = so;
      sck = 1'b0;
    end
  endtask : xfer

  // Select stays low for the whole frame, released only here
  task automatic stop();
    half();
    cs_n = 1'b1;
    si   = ~si;  // Released line never keeps its last value
    repeat (2) half();
  endtask : stop
endmodule : fsrb_host_model
`default_nettype wire

// ==== tb/serial_flash_read_buffer_program_tb.sv ====
// Testbench for the serial flash front end: host model, array model, scenarios.
// Assumes reads answer within one SCK half period and programs are self-timed.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_buffer_program_tb;
  logic                    clk_sys;
  logic                    nrst;
  logic                    cs_n;
  logic                    sck;
  logic                    si;
  logic                    page_264;
  logic                    so;
  logic                    so_oe;
  logic                    so_line;
  logic                    busy;
  fsrb_pkg::fsrb_arr_req_t arr_req;
  logic [7:0]              arr_rdata;
  logic [7:0]              mem [logic [20:0]];
  logic [7:0]              exp_q [$];
  logic [7:0]              rx;
  int                      miscompares;
  int                      total_checks;
  int                      we_cnt;

  fsrb_core i_fsrb_core (.clk_sys(clk_sys), .nrst(nrst), .cs_n_pin(cs_n), .sck_pin(sck),
    .si_pin(si), .page_264_pin(page_264), .so_o(so), .so_oe(so_oe), .busy(busy),
    .arr_req(arr_req), .arr_rdata(arr_rdata));
  fsrb_host_model i_fsrb_host_model (.clk_sys(clk_sys), .so(so_line), .cs_n(cs_n), .sck(sck),
    .si(si));

  // Released SO shows the inverse of its last level, so a late drive is caught
  assign so_line = so_oe ? so : ~so;

  // 100 MHz system clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // Unwritten array bytes follow a pattern so page crossings are visible
  function automatic logic [7:0] pat(input logic [11:0] p, input logic [8:0] c);
    return p[7:0] ^ c[7:0] ^ {p[11:8], 3'h0, c[8]} ^ 8'h5a;
  endfunction : pat

  // Synchronous array: data the cycle after a read strobe
  always @(posedge clk_sys)
  begin
    if (arr_req.re)
      arr_rdata <= mem.exists({arr_req.page, arr_req.col}) ?
                   mem[{arr_req.page, arr_req.col}] : pat(arr_req.page, arr_req.col);
    if (arr_req.we)
    begin
      mem[{arr_req.page, arr_req.col}] = arr_req.wdata;
      we_cnt++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Opcode, three address bytes, dummies; select left low
  task automatic hdr(input logic [7:0] opc, input logic [23:0] adr, input int ndum);
    i_fsrb_host_model.start();
    i_fsrb_host_model.xfer(opc, rx);
    for (int k = 2; k >= 0; k--)
      i_fsrb_host_model.xfer(adr[8*k +: 8], rx);
    repeat (ndum) i_fsrb_host_model.xfer(8'h00, rx);
  endtask : hdr

  // Read frame judged against exp_q, then output release
  task automatic rd_chk(input logic [7:0] opc, input logic [23:0] adr, input int ndum);
    hdr(opc, adr, ndum);
    foreach (exp_q[i])
    begin
      i_fsrb_host_model.xfer(8'h00, rx);
      chk(rx, exp_q[i]);
    end
    chk(so_oe, 1'b1);
    i_fsrb_host_model.stop();
    chk(so_oe, 1'b0);
  endtask : rd_chk

  // Three bytes from the last column, so the index wraps
  task automatic buf_wr(input logic [7:0] opc, input logic [23:0] adr, input logic [7:0] d0);
    hdr(opc, adr, 0);
    for (int k = 0; k < 3; k++)
      i_fsrb_host_model.xfer(d0 + 8'(k), rx);
    i_fsrb_host_model.stop();
  endtask : buf_wr

  // Every buffer read opcode, each from the last column across the wrap
  task automatic s_bufread();
    logic [7:0] opc [4];
    logic [7:0] d;
    opc = '{fsrb_pkg::OPC_BR1_HI, fsrb_pkg::OPC_BR1_LO, fsrb_pkg::OPC_BR2_HI,
            fsrb_pkg::OPC_BR2_LO};
    for (int i = 0; i < 4; i++)
    begin
      d = (i < 2) ? 8'ha1 : 8'hb1;
      exp_q = '{d, d + 8'h01, d + 8'h02};
      rd_chk(opc[i], 24'h0000ff, 1);
    end
  endtask : s_bufread

  // Both buffers loaded; ignored address bits 23:12 set high on the first
  task automatic s_buffers();
    buf_wr(fsrb_pkg::OPC_BW1, 24'hfff0ff, 8'ha1);
    buf_wr(fsrb_pkg::OPC_BW2, 24'h0000ff, 8'hb1);
    s_bufread();
  endtask : s_buffers

  // Array reads across page, array end and in-page wrap, both page sizes
  task automatic s_cont();
    exp_q = '{pat(12'h005, 9'h0fe), pat(12'h005, 9'h0ff), pat(12'h006, 9'h000)};
    rd_chk(fsrb_pkg::OPC_RD_LO, 24'h0005fe, 0);
    page_264 = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    exp_q = '{pat(12'hfff, 9'h106), pat(12'hfff, 9'h107), pat(12'h000, 9'h000)};
    rd_chk(fsrb_pkg::OPC_RD_HI, {3'h0, 12'hfff, 9'h106}, 1);
    exp_q = '{pat(12'h007, 9'h107), pat(12'h007, 9'h000)};
    rd_chk(fsrb_pkg::OPC_PG_RD, {3'h0, 12'h007, 9'h107}, 4);
    page_264 = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    s_bufread();
  endtask : s_cont

  // Program each buffer into its own page, last pass in 264 mode; busy bounded by a loop
  task automatic s_prog();
    logic [7:0]  d;
    logic        big;
    logic [11:0] pg;
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 1) ? 8'hb1 : 8'ha1;
      big = (i == 2);
      pg = 12'h009 + 12'(i);
      page_264 = big;
      repeat (8) @(posedge clk_sys);
      #1;
      we_cnt = 0;
      hdr((i == 1) ? fsrb_pkg::OPC_PE2 : fsrb_pkg::OPC_PE1,
          big ? {3'h7, pg, 9'h1ff} : {4'hf, pg, 8'hff}, 0);
      i_fsrb_host_model.stop();
      chk(busy, 1'b1);
      for (int n = 0; n < 2000 && busy === 1'b1; n++)
      begin
        @(posedge clk_sys);
        #1;
      end
      if (busy !== 1'b0)
      begin
        miscompares++;
        report_and_stop();
      end
      // Last array write lands one clock after busy drops
      repeat (2) @(posedge clk_sys);
      #1;
      chk(we_cnt, big ? 528 : 512);
      exp_q = '{d + 8'h01, d + 8'h02};
      rd_chk(fsrb_pkg::OPC_RD_LO, big ? {3'h0, pg, 9'h000} : {4'h0, pg, 8'h00}, 0);
    end
    page_264 = 1'b0;
  endtask : s_prog

  // Reset, then the scenarios in order
  initial
  begin
    nrst = 1'b0;
    page_264 = 1'b0;
    arr_rdata = 8'h00;
    miscompares = 0;
    total_checks = 0;
    we_cnt = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    s_buffers();
    s_cont();
    s_prog();
    report_and_stop();
  end
endmodule : serial_flash_read_buffer_program_tb
`default_nettype wire
